// >>> core/late_write_pkg.sv
// shared constants and carrier types for the late-write synchronous sram core
// assumes a single 40 MHz clock; all host pins except sleep and impedance target are synchronous to it
package late_write_pkg;

  // ------------------------------------------------------------------
  // organisation
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned LANES      = 4;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned DATA_W     = LANES * LANE_W;
  localparam int unsigned FIFO_DEPTH = 2;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS        = 25000;
  localparam int unsigned SLEEP_RECOVERY_NS    = 10;
  localparam int unsigned SLEEP_RECOVERY_RAW   = (SLEEP_RECOVERY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SLEEP_RECOVERY_CYC   = (SLEEP_RECOVERY_RAW < 1) ? 1 : SLEEP_RECOVERY_RAW;
  localparam int unsigned IMP_CONVERGE_CYCLES  = 65000;
  localparam int unsigned IMP_LEVELS           = 256;
  localparam int unsigned IMP_W                = 8;
  localparam int unsigned IMP_STEP_CYCLES      = IMP_CONVERGE_CYCLES / (IMP_LEVELS - 1);
  localparam logic [7:0]  IMP_RESET_CODE       = 8'h80;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_en;
  } cmd_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_en;
    logic [DATA_W-1:0] data;
  } wbuf_t;

endpackage : late_write_pkg

// >>> core/late_write_sram_core.sv
// late-write synchronous sram core: registered controls, one-stage write buffer with
// forwarding, output drive control, stepped impedance code and asynchronous sleep
// assumes address, select, write and lane enables and write data are synchronous to sys_clk_i;
// sleep_request_i and impedance_target_i are asynchronous
`timescale 1ns/1ps

// Summary of operation
// RULE1: capture controls on every rising clock edge
// RULE2: read data registered next edge, reads pipeline
// RULE3: host leaves dead cycle before a write
// RULE4: read right after write is served
// RULE5: deselect turns drivers off after next edge
// RULE6: write turns drivers off in same cycle
// RULE7: one lane enable per nine-bit lane
// RULE8: lane enables ignored on reads
// RULE9: write only lanes whose enables are low
// RULE10: write cycle returns no read data
// RULE11: write without lanes changes nothing
// RULE12: write data sampled one edge after address
// RULE13: single write buffer forwards matching reads
// RULE14: commit buffer no later than next write
// RULE15: impedance changes only when nothing is driven
// RULE16: 256-level code moves in single steps
// RULE17: impedance converges within 65,000 cycles
// RULE18: impedance code kept across sleep
// RULE19: host waits 1.0 ms after power-up
// RULE20: sleep input asynchronous, active high
// RULE21: host idles two cycles before sleep
// RULE22: host idles during sleep recovery
// RULE23: asleep: deselected, outputs off, no access
module late_write_sram_core
  import late_write_pkg::*;
#(
  parameter int unsigned AW         = ADDR_W,
  parameter int unsigned NL         = LANES,
  parameter int unsigned LW         = LANE_W,
  parameter int unsigned DEPTH      = FIFO_DEPTH,
  parameter int unsigned STEP_CYC   = IMP_STEP_CYCLES,
  parameter int unsigned RECOVER_CYC = SLEEP_RECOVERY_CYC
) (
  input  wire logic                sys_clk_i,           // 40 MHz core clock
  input  wire logic                rst_i,               // synchronous reset, active high
  input  wire logic [AW-1:0]       addr_i,              // address
  input  wire logic                chip_select_n_i,     // chip select, active low
  input  wire logic                write_enable_n_i,    // write enable, active low
  input  wire logic [NL-1:0]       byte_lane_write_n_i, // lane write enables, active low
  input  wire logic [NL*LW-1:0]    wr_data_i,           // late write data
  output logic      [NL*LW-1:0]    rd_data_o,           // read data from buffer flops
  output logic                     rd_valid_o,          // read word present and driven
  input  wire logic                rd_ready_i,          // receiver takes the word
  output logic                     data_oe_o,           // data driver enable
  output logic                     cmd_ready_o,         // a read may be issued this edge
  input  wire logic                sleep_request_i,     // asynchronous sleep, active high
  output logic                     asleep_o,            // core is asleep or recovering
  input  wire logic [IMP_W-1:0]    impedance_target_i,  // code from reference comparator
  output logic      [IMP_W-1:0]    impedance_code_o,    // current driver impedance code
  output logic                     impedance_locked_o   // code equals target
);

  localparam int unsigned DW  = NL * LW;
  localparam int unsigned PW  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW  = $clog2(DEPTH + 1);
  localparam int unsigned SCW = $clog2(STEP_CYC + 1);
  localparam int unsigned RW  = $clog2(RECOVER_CYC + 1);

  // ------------------------------------------------------------------
  // asynchronous inputs
  // ------------------------------------------------------------------
  logic             sleep_meta_reg, sleep_sync_reg;
  logic [IMP_W-1:0] imp_meta_reg, imp_sync_reg;

  // the target code is assumed to move slowly, so a torn sample only delays one step
  always_ff @(posedge sys_clk_i) begin
    sleep_meta_reg <= sleep_request_i;  // [RULE20]
    sleep_sync_reg <= sleep_meta_reg;
    imp_meta_reg   <= impedance_target_i;
    imp_sync_reg   <= imp_meta_reg;
  end

  // ------------------------------------------------------------------
  // sleep and recovery
  // ------------------------------------------------------------------
  logic [RW-1:0] recover_reg, recover_next;
  logic          active;

  assign active = !sleep_sync_reg && (recover_reg == '0);  // [RULE23]
  assign asleep_o = !active;

  always_comb begin
    recover_next = recover_reg;
    if (sleep_sync_reg) begin
      recover_next = RW'(RECOVER_CYC);
    end else if (recover_reg != '0) begin
      recover_next = recover_reg - RW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) recover_reg <= '0;
    else       recover_reg <= recover_next;
  end

  // ------------------------------------------------------------------
  // command capture
  // ------------------------------------------------------------------
  logic          selected, take_wr, take_rd, rd_credit_ok;
  cmd_t          cmd_reg;
  logic          rd_s1_reg, wr_s1_reg, desel_s1_reg, desel_s2_reg, rd_s2_reg;
  logic [CW-1:0] count_reg, count_after;
  logic          pop, push;

  assign selected = !chip_select_n_i && active;
  assign take_wr  = selected && !write_enable_n_i;
  assign take_rd  = selected && write_enable_n_i && rd_credit_ok;  // [RULE8]

  // a read is only taken if the buffer can hold it together with those in flight
  assign count_after  = count_reg - CW'(pop);
  assign rd_credit_ok = (32'(count_after) + 32'(rd_s1_reg) + 32'(rd_s2_reg)) < DEPTH;
  assign cmd_ready_o  = rd_credit_ok && active;

  always_ff @(posedge sys_clk_i) begin
    cmd_reg.addr    <= addr_i;                 // [RULE1]
    cmd_reg.lane_en <= ~byte_lane_write_n_i;   // [RULE7]
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !active) begin
      rd_s1_reg    <= 1'b0;
      wr_s1_reg    <= 1'b0;
      rd_s2_reg    <= 1'b0;
      desel_s1_reg <= 1'b1;
      desel_s2_reg <= 1'b1;
    end else begin
      rd_s1_reg    <= take_rd;                 // [RULE2]
      wr_s1_reg    <= take_wr;
      rd_s2_reg    <= rd_s1_reg;
      desel_s1_reg <= !selected;
      desel_s2_reg <= desel_s1_reg;            // [RULE5]
    end
  end

  // ------------------------------------------------------------------
  // late write buffer and forwarding
  // ------------------------------------------------------------------
  wbuf_t         wbuf_reg, wbuf_next;
  logic          commit, fwd_hit;
  logic [NL-1:0] fwd_lane_reg;
  logic [DW-1:0] fwd_data_reg, mem_rd_data, merged;

  // the older write goes to the array on the edge the newer data arrives
  assign commit = wr_s1_reg && wbuf_reg.valid;  // [RULE14]

  always_comb begin
    wbuf_next = wbuf_reg;
    if (wr_s1_reg) begin
      wbuf_next.valid   = |cmd_reg.lane_en;    // [RULE11]
      wbuf_next.addr    = cmd_reg.addr;
      wbuf_next.lane_en = cmd_reg.lane_en;     // [RULE9]
      wbuf_next.data    = wr_data_i;           // [RULE12]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) wbuf_reg <= '0;
    else       wbuf_reg <= wbuf_next;
  end

  assign fwd_hit = wbuf_reg.valid && (wbuf_reg.addr == cmd_reg.addr);  // [RULE13]

  always_ff @(posedge sys_clk_i) begin
    fwd_lane_reg <= (rd_s1_reg && fwd_hit) ? wbuf_reg.lane_en : '0;    // [RULE4]
    fwd_data_reg <= wbuf_reg.data;
  end

  sram_array #(
    .ADDR_W (AW),
    .LANES  (NL),
    .LANE_W (LW)
  ) u_array (
    .sys_clk_i (sys_clk_i),
    .rd_en_i   (rd_s1_reg),
    .rd_addr_i (cmd_reg.addr),
    .rd_data_o (mem_rd_data),
    .wr_en_i   (commit),
    .wr_addr_i (wbuf_reg.addr),
    .wr_lane_i (wbuf_reg.lane_en),
    .wr_data_i (wbuf_reg.data)
  );

  for (genvar l = 0; l < NL; l++) begin : g_merge
    assign merged[l*LW +: LW] = fwd_lane_reg[l] ? fwd_data_reg[l*LW +: LW] : mem_rd_data[l*LW +: LW];
  end

  // ------------------------------------------------------------------
  // read data buffer
  // ------------------------------------------------------------------
  logic [DW-1:0] fifo_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic          fifo_in_ready, fifo_out_valid, drive_ok;

  // only read cycles push; a write cycle never produces a word
  assign fifo_in_ready  = count_reg < CW'(DEPTH);
  assign push           = rd_s2_reg && fifo_in_ready;  // [RULE10]
  assign fifo_out_valid = count_reg != '0;

  // driver enable: a sampled write kills it at once, a deselect one edge later
  assign drive_ok   = active && !wr_s1_reg && !desel_s2_reg;  // [RULE6]
  assign data_oe_o  = fifo_out_valid && drive_ok;
  assign rd_valid_o = data_oe_o;
  assign pop        = rd_valid_o && rd_ready_i;
  assign rd_data_o  = fifo_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk_i) begin
    if (push) fifo_reg[wr_ptr_reg] <= merged;
  end

  // sleep drops queued words; the host may not rely on them anyway
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || sleep_sync_reg) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (32'(wr_ptr_reg) == DEPTH - 1) ? '0 : wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= (32'(rd_ptr_reg) == DEPTH - 1) ? '0 : rd_ptr_reg + PW'(1);
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  // ------------------------------------------------------------------
  // output impedance code
  // ------------------------------------------------------------------
  logic [IMP_W-1:0] imp_code_reg, imp_code_next;
  logic [SCW-1:0]   step_cnt_reg;
  logic             step_due_reg, imp_window, step_tick, locked_reg;

  // stepping is allowed only in write or deselected cycles with nothing driven
  assign imp_window = active && !data_oe_o && !rd_s1_reg && !rd_s2_reg
                      && (wr_s1_reg || desel_s1_reg);  // [RULE15]
  assign step_tick  = 32'(step_cnt_reg) == STEP_CYC - 1;

  always_comb begin
    imp_code_next = imp_code_reg;
    if (step_due_reg && imp_window) begin
      if (imp_code_reg < imp_sync_reg)      imp_code_next = imp_code_reg + IMP_W'(1);  // [RULE16]
      else if (imp_code_reg > imp_sync_reg) imp_code_next = imp_code_reg - IMP_W'(1);
    end
  end

  // one step per STEP_CYC cycles covers the full range inside the convergence bound
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      imp_code_reg <= IMP_RESET_CODE;
      step_cnt_reg <= '0;
      step_due_reg <= 1'b0;
      locked_reg   <= 1'b0;
    end else if (active) begin
      step_cnt_reg <= step_tick ? '0 : step_cnt_reg + SCW'(1);                    // [RULE17]
      step_due_reg <= step_tick || (step_due_reg && !imp_window);
      imp_code_reg <= imp_code_next;
      locked_reg   <= imp_code_next == imp_sync_reg;
    end
    // asleep the code simply holds, so wake-up resumes from it  [RULE18]
  end

  assign impedance_code_o   = imp_code_reg;
  assign impedance_locked_o = locked_reg;

endmodule : late_write_sram_core

// >>> core/sram_array.sv
// storage array with one registered read port and one byte-lane write port
// assumes read and write addresses come from the same clock; no reset of contents
`timescale 1ns/1ps
module sram_array #(
  parameter int unsigned ADDR_W = 18,
  parameter int unsigned LANES  = 4,
  parameter int unsigned LANE_W = 9
) (
  input  wire logic                     sys_clk_i,   // core clock
  input  wire logic                     rd_en_i,     // read strobe
  input  wire logic [ADDR_W-1:0]        rd_addr_i,   // read address
  output logic      [LANES*LANE_W-1:0]  rd_data_o,   // registered read word
  input  wire logic                     wr_en_i,     // write strobe
  input  wire logic [ADDR_W-1:0]        wr_addr_i,   // write address
  input  wire logic [LANES-1:0]         wr_lane_i,   // lanes to write
  input  wire logic [LANES*LANE_W-1:0]  wr_data_i    // write word
);

  logic [LANES*LANE_W-1:0] mem_reg [2**ADDR_W];

  // read-before-write on a shared address; the core forwards the newer bytes
  always_ff @(posedge sys_clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en_i && wr_lane_i[l]) begin
        mem_reg[wr_addr_i][l*LANE_W +: LANE_W] <= wr_data_i[l*LANE_W +: LANE_W];
      end
    end
  end

endmodule : sram_array

// >>> tb/host_ctrl_model.sv
// host model: commands, late write data and the read-word receiver
// assumes its tasks are called just after a rising edge of sys_clk_i
`timescale 1ns/1ps
module host_ctrl_model
  import late_write_pkg::*;
(
  input  wire logic              sys_clk_i,   // clock
  input  wire logic              cmd_ready_i, // read credit
  output logic      [ADDR_W-1:0] addr_o,      // address
  output logic                   cs_n_o,      // select
  output logic                   we_n_o,      // write
  output logic      [LANES-1:0]  lane_n_o,    // lanes
  output logic      [DATA_W-1:0] wdata_o,     // wdata
  output logic                   ready_o      // takes words
);
  logic [DATA_W-1:0] next_data;
  logic              stall;
  logic              last_rd;
  initial begin
    {addr_o, lane_n_o, wdata_o, next_data} = '0;
    {cs_n_o, we_n_o} = 2'b11;
    {ready_o, stall, last_rd} = 3'b000;
  end
  // outside its data cycle the bus toggles, so a stale word never passes for data
  always @(posedge sys_clk_i) begin
    wdata_o <= (!cs_n_o && !we_n_o) ? next_data : ~wdata_o;
    ready_o <= !stall;
  end
  task automatic idle(input int n);
    cs_n_o <= 1'b1;
    we_n_o <= 1'b1;
    last_rd = 1'b0;
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d);
    if (last_rd)
      idle(1);
    cs_n_o <= 1'b0;
    we_n_o <= 1'b0;
    addr_o <= a;
    lane_n_o <= ln;
    next_data <= d;
    @(posedge sys_clk_i);
  endtask : do_write
  task automatic present_read(input logic [ADDR_W-1:0] a);
    cs_n_o <= 1'b0;
    we_n_o <= 1'b1;
    addr_o <= a;
    lane_n_o <= 4'h5;
    last_rd = 1'b1;
    @(posedge sys_clk_i);
  endtask : present_read
  task automatic do_read(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    do begin
      present_read(a);
      n++;
    end while (cmd_ready_i !== 1'b1 && n < 20);
  endtask : do_read
endmodule : host_ctrl_model

// >>> tb/late_write_sram_core_asserts.sv
// port checks for the late-write sram core
// assumes one clock domain and the core's synchronous reset
`timescale 1ns/1ps
module late_write_sram_core_asserts
  import late_write_pkg::*;
(
  input wire logic              sys_clk_i,           // clock
  input wire logic              rst_i,               // reset
  input wire logic [ADDR_W-1:0] addr_i,              // address
  input wire logic              chip_select_n_i,     // select
  input wire logic              write_enable_n_i,    // write
  input wire logic [LANES-1:0]  byte_lane_write_n_i, // lanes
  input wire logic [DATA_W-1:0] wr_data_i,           // wdata
  input wire logic [DATA_W-1:0] rd_data_o,           // rdata
  input wire logic              rd_valid_o,          // valid
  input wire logic              rd_ready_i,          // ready
  input wire logic              data_oe_o,           // drive
  input wire logic              cmd_ready_o,         // credit
  input wire logic              sleep_request_i,     // sleep
  input wire logic              asleep_o,            // asleep
  input wire logic [IMP_W-1:0]  impedance_target_i,  // target
  input wire logic [IMP_W-1:0]  impedance_code_o,    // code
  input wire logic              impedance_locked_o   // locked
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_take_s;
    !chip_select_n_i && write_enable_n_i && cmd_ready_o && !asleep_o && !rd_valid_o;
  endsequence
  sequence rd_run_s;
    (!chip_select_n_i && write_enable_n_i && !sleep_request_i && !asleep_o) [*3];
  endsequence
  sequence wr_take_s;
    !chip_select_n_i && !write_enable_n_i && !asleep_o;
  endsequence
  rd_latency_a: assert property (rd_take_s ##1 rd_run_s |-> rd_valid_o)
    else $error("read word late");
  rd_hold_a: assert property (
    rd_valid_o && !rd_ready_i && !asleep_o && !sleep_request_i && !$past(sleep_request_i) |=> $stable(rd_data_o))
    else $error("stalled word changed");
  wr_off_a: assert property (wr_take_s |=> !data_oe_o)
    else $error("drivers on after write");
  wr_noread_a: assert property (wr_take_s |=> !rd_valid_o)
    else $error("read data in write cycle");
  nolane_off_a: assert property (wr_take_s ##0 byte_lane_write_n_i == 4'hf |=> !data_oe_o)
    else $error("drivers on after empty write");
  desel_off_a: assert property (chip_select_n_i [*2] |-> ##2 !data_oe_o)
    else $error("drivers on after deselect");
  sleep_off_a: assert property (asleep_o [*3] |-> !data_oe_o && !rd_valid_o)
    else $error("drivers on while asleep");
  sleep_code_a: assert property (asleep_o [*3] |-> $stable(impedance_code_o))
    else $error("code moved while asleep");
  imp_step_a: assert property (
    !$stable(impedance_code_o) |-> impedance_code_o == $past(impedance_code_o) + 8'h01
      || impedance_code_o == $past(impedance_code_o) - 8'h01)
    else $error("code jumped");
  imp_quiet_a: assert property ($changed(impedance_code_o) |-> !$past(data_oe_o))
    else $error("code moved while driving");
  sequence target_steady_s;
    $stable(impedance_target_i) [*4];
  endsequence
  imp_lock_a: assert property (
    target_steady_s ##0 (!$past(asleep_o) && !$past(rst_i))
      |-> impedance_locked_o == (impedance_code_o == impedance_target_i))
    else $error("lock flag disagrees with code");
endmodule : late_write_sram_core_asserts

bind late_write_sram_core late_write_sram_core_asserts u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .chip_select_n_i(chip_select_n_i),
  .write_enable_n_i(write_enable_n_i), .byte_lane_write_n_i(byte_lane_write_n_i), .wr_data_i(wr_data_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .data_oe_o(data_oe_o),
  .cmd_ready_o(cmd_ready_o), .sleep_request_i(sleep_request_i), .asleep_o(asleep_o),
  .impedance_target_i(impedance_target_i), .impedance_code_o(impedance_code_o),
  .impedance_locked_o(impedance_locked_o));

// >>> tb/late_write_sync_sram_core_test.sv
// self-checking bench: host model in front of the core, shadow memory judges read words
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module late_write_sync_sram_core_test
  import late_write_pkg::*;
;
  // the host keeps the clock running 1.0 ms (40,000 cycles of 25 ns) before any access
  localparam int unsigned DWELL_CYC = 40000;
  localparam int unsigned WATCH_CYC = DWELL_CYC + 2000;
  logic              sys_clk_i, rst_i, chip_select_n_i, write_enable_n_i, rd_valid_o, rd_ready_i;
  logic              data_oe_o, cmd_ready_o, sleep_request_i, asleep_o, impedance_locked_o, wr_pend;
  logic [ADDR_W-1:0] addr_i, wr_a;
  logic [LANES-1:0]  byte_lane_write_n_i, wr_ln;
  logic [DATA_W-1:0] wr_data_i, rd_data_o, mem [8], expq [$];
  logic [IMP_W-1:0]  impedance_target_i, impedance_code_o;
  int                bad_count = 0;
  int                compares = 0;
  late_write_sram_core #(.STEP_CYC(2)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .chip_select_n_i(chip_select_n_i),
    .write_enable_n_i(write_enable_n_i), .byte_lane_write_n_i(byte_lane_write_n_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .data_oe_o(data_oe_o),
    .cmd_ready_o(cmd_ready_o), .sleep_request_i(sleep_request_i), .asleep_o(asleep_o),
    .impedance_target_i(impedance_target_i), .impedance_code_o(impedance_code_o),
    .impedance_locked_o(impedance_locked_o));
  host_ctrl_model u_host (.sys_clk_i(sys_clk_i), .cmd_ready_i(cmd_ready_o), .addr_o(addr_i),
    .cs_n_o(chip_select_n_i), .we_n_o(write_enable_n_i), .lane_n_o(byte_lane_write_n_i), .wdata_o(wr_data_i),
    .ready_o(rd_ready_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check_word(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word
  task automatic check_flag(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : check_flag
  // shadow: a write lands at its data edge, before a read taken on that same edge
  always @(posedge sys_clk_i) begin
    if (wr_pend)
      for (int l = 0; l < LANES; l++)
        if (!wr_ln[l])
          mem[wr_a[2:0]][l*LANE_W +: LANE_W] = wr_data_i[l*LANE_W +: LANE_W];
    wr_pend = !rst_i && !asleep_o && !chip_select_n_i && !write_enable_n_i;
    wr_a = addr_i;
    wr_ln = byte_lane_write_n_i;
    if (!rst_i && !asleep_o && !chip_select_n_i && write_enable_n_i && cmd_ready_o)
      expq.push_back(mem[addr_i[2:0]]);
    if (!rst_i && rd_valid_o && rd_ready_i)
      check_word("read word", expq.size() > 0 ? expq.pop_front() : ~rd_data_o, rd_data_o);
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic drain();
    repeat (6)
      u_host.present_read(18'h0);
    u_host.idle(1);
    check_flag("words in flight", 1'b1, expq.size() <= 2);
  endtask : drain
  task automatic sc_write_read();
    u_host.do_write(18'h0, 4'h0, 36'h123456789);
    u_host.do_write(18'h1, 4'h0, 36'hfedcba987);
    u_host.do_read(18'h1);
    u_host.do_read(18'h0);
    u_host.do_read(18'h1);
    drain();
  endtask : sc_write_read
  task automatic sc_lanes();
    u_host.do_write(18'h2, 4'h0, 36'h0);
    for (int l = 0; l < LANES; l++) begin
      u_host.do_write(18'h2, ~(4'h1 << l), 36'h1a5a5a5a5 ^ (36'h1ff << (l * LANE_W)));
      u_host.do_read(18'h2);
    end
    u_host.do_write(18'h2, 4'hf, 36'h0);
    u_host.do_read(18'h2);
    drain();
  endtask : sc_lanes
  task automatic sc_stall();
    logic refused;
    refused = 1'b0;
    u_host.stall <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      u_host.present_read(18'(i % 2));
      refused |= (cmd_ready_o === 1'b0);
    end
    check_flag("read refused when full", 1'b1, refused);
    u_host.stall <= 1'b0;
    drain();
  endtask : sc_stall
  task automatic sc_imp();
    impedance_target_i <= 8'h83;
    u_host.idle(4);
    for (int i = 0; i < 100 && impedance_locked_o !== 1'b1; i++)
      u_host.idle(1);
    check_word("impedance code", {28'h0, 8'h83}, {28'h0, impedance_code_o});
    check_flag("impedance locked", 1'b1, impedance_locked_o);
  endtask : sc_imp
  task automatic sc_sleep();
    u_host.idle(2);
    sleep_request_i <= 1'b1;
    for (int i = 0; i < 10 && asleep_o !== 1'b1; i++)
      u_host.idle(1);
    expq.delete();
    impedance_target_i <= 8'h70;
    u_host.do_write(18'h0, 4'h0, 36'h0);
    u_host.idle(4);
    check_flag("asleep", 1'b1, asleep_o);
    check_flag("drive asleep", 1'b0, data_oe_o);
    sleep_request_i <= 1'b0;
    for (int i = 0; i < 10 && asleep_o !== 1'b0; i++)
      u_host.idle(1);
    check_word("code after sleep", {28'h0, 8'h83}, {28'h0, impedance_code_o});
    impedance_target_i <= 8'h83;
    u_host.do_read(18'h0);
    drain();
  endtask : sc_sleep
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (WATCH_CYC) @(posedge sys_clk_i);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    sleep_request_i = 1'b0;
    impedance_target_i = 8'h80;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (DWELL_CYC) @(posedge sys_clk_i);
    check_word("reset code", {28'h0, 8'h80}, {28'h0, impedance_code_o});
    sc_write_read();
    sc_lanes();
    sc_stall();
    sc_imp();
    sc_sleep();
    wrap_up();
  end
endmodule : late_write_sync_sram_core_test
